// [core/fast_ethernet_line_coding_path.v]
// transmit 4B/5B, scrambler, NRZI, MLT-3 and receive MLT-3 to symbols
`timescale 1ns/1ns
`default_nettype none
`include "line_coding_defines.vh"
module fast_ethernet_line_coding_path #(
  parameter SD_THRESHOLD = 8
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       bitEn,
  input  wire       txEn,
  input  wire [3:0] txData,
  input  wire       txErr,
  input  wire [4:0] phy_address_strap,
  output reg        txNibbleTake,
  output reg        mltPlus,
  output reg        mltMinus,
  input  wire       lineUp,
  input  wire       lineDown,
  output reg  [4:0] rxSymbol,
  output reg        rxSymbolValid,
  output reg        rxSerialNrz,
  output reg        rxSerialValid,
  output reg        signalDetect
);

  // ------------------------------------------------------------
  // 4B/5B lookup
  // ------------------------------------------------------------
  function [4:0] enc4b5b;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc4b5b = 5'h1E;
        4'h1: enc4b5b = 5'h09;
        4'h2: enc4b5b = 5'h14;
        4'h3: enc4b5b = 5'h15;
        4'h4: enc4b5b = 5'h0A;
        4'h5: enc4b5b = 5'h0B;
        4'h6: enc4b5b = 5'h0E;
        4'h7: enc4b5b = 5'h0F;
        4'h8: enc4b5b = 5'h12;
        4'h9: enc4b5b = 5'h13;
        4'hA: enc4b5b = 5'h16;
        4'hB: enc4b5b = 5'h17;
        4'hC: enc4b5b = 5'h1A;
        4'hD: enc4b5b = 5'h1B;
        4'hE: enc4b5b = 5'h1C;
        default: enc4b5b = 5'h1D;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  // each state names the code-group now on its way out
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SSD1 = 3'h1;
  localparam [2:0] ST_SSD2 = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_ESD1 = 3'h4;
  localparam [2:0] ST_ESD2 = 3'h5;

  // ------------------------------------------------------------
  // line level synchronisers
  // ------------------------------------------------------------
  reg  [1:0] upSync_q;
  reg  [1:0] downSync_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      upSync_q   <= 2'h0;
      downSync_q <= 2'h0;
    end else begin
      upSync_q   <= {upSync_q[0], lineUp};
      downSync_q <= {downSync_q[0], lineDown};
    end
  end

  // ------------------------------------------------------------
  // strap synchroniser
  // ------------------------------------------------------------
  // no reset: the seed is caught on the first edge after release
  reg  [4:0] strapMeta_q;
  reg  [4:0] strapSync_q;

  always @(posedge clock) begin
    strapMeta_q <= phy_address_strap;
    strapSync_q <= strapMeta_q;
  end

  // ------------------------------------------------------------
  // transmit code-group sequencer
  // ------------------------------------------------------------
  reg  [2:0] txState_q;
  reg  [2:0] txState_d;
  reg  [4:0] txShift_q;
  reg  [4:0] txLoad;
  reg  [2:0] bitCnt_q;
  reg        seedLoaded_q;
  // no group closes before the seed is in, so no nibble is taken unused
  wire       cgDone = bitEn && seedLoaded_q && (bitCnt_q == `BITS_PER_CG - 3'h1);

  always @* begin
    txState_d    = txState_q;
    txLoad       = `CG_IDLE;
    txNibbleTake = 1'b0;
    case (txState_q)
      ST_IDLE, ST_ESD2: begin
        if (txEn) begin
          txLoad       = `CG_SSD1;
          txState_d    = ST_SSD1;
          txNibbleTake = 1'b1;
        end else begin
          txLoad    = `CG_IDLE;
          txState_d = ST_IDLE;
        end
      end
      ST_SSD1: begin
        txLoad       = `CG_SSD2;
        txNibbleTake = 1'b1;
        txState_d    = ST_SSD2;
      end
      ST_SSD2, ST_DATA: begin
        if (!txEn) begin
          txLoad    = `CG_ESD1;
          txState_d = ST_ESD1;
        end else begin
          // error from the mac is carried as halt
          txLoad       = txErr ? `CG_HALT : enc4b5b(txData);
          txNibbleTake = 1'b1;
          txState_d    = ST_DATA;
        end
      end
      ST_ESD1: begin
        txLoad    = `CG_ESD2;
        txState_d = ST_ESD2;
      end
      default: begin
        txLoad    = `CG_IDLE;
        txState_d = ST_IDLE;
      end
    endcase
    if (!cgDone) begin
      txNibbleTake = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // code-group serialiser
  // ------------------------------------------------------------
  // msb leaves first; a fresh group loads as the last bit goes out
  always @(posedge clock) begin
    if (!rst_n) begin
      txState_q <= ST_IDLE;
      txShift_q <= `CG_IDLE;
      bitCnt_q  <= 3'h0;
    end else if (bitEn && seedLoaded_q) begin
      if (cgDone) begin
        bitCnt_q  <= 3'h0;
        txShift_q <= txLoad;
        txState_q <= txState_d;
      end else begin
        bitCnt_q  <= bitCnt_q + 3'h1;
        txShift_q <= {txShift_q[3:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // scrambler seed and LFSR
  // ------------------------------------------------------------
  reg  [`LFSR_W-1:0] lfsr_q;
  wire               lfsrFb = lfsr_q[10] ^ lfsr_q[8];

  always @(posedge clock) begin
    if (!rst_n) begin
      lfsr_q       <= `LFSR_RST;
      seedLoaded_q <= 1'b0;
    end else if (!seedLoaded_q) begin
      // the mix keeps every strap value away from the locked zero state
      lfsr_q       <= {6'h00, strapSync_q} ^ `SEED_MIX;
      seedLoaded_q <= 1'b1;
    end else if (bitEn) begin
      lfsr_q <= {lfsr_q[9:0], lfsrFb};
    end
  end

  // ------------------------------------------------------------
  // scramble, NRZI and MLT-3 drive phases
  // ------------------------------------------------------------
  reg                nrzi_q;
  reg                mltPhase_q;
  wire               scrBit  = txShift_q[4] ^ lfsrFb;
  wire               nrziNxt = nrzi_q ^ scrBit;

  // line bits trail their bitEn by one clock
  always @(posedge clock) begin
    if (!rst_n) begin
      nrzi_q     <= 1'b0;
      mltPhase_q <= 1'b0;
      mltPlus    <= 1'b0;
      mltMinus   <= 1'b0;
    end else if (bitEn && seedLoaded_q) begin
      nrzi_q <= nrziNxt;
      // side swaps as the level falls, so the next high uses the other side
      if (nrzi_q && !nrziNxt) begin
        mltPhase_q <= ~mltPhase_q;
      end
      mltPlus  <= nrziNxt & ~mltPhase_q;
      mltMinus <= nrziNxt &  mltPhase_q;
    end
  end

  // ------------------------------------------------------------
  // receive: MLT-3 to NRZI to NRZ, then 5-bit symbols
  // ------------------------------------------------------------
  wire [1:0] rxLevel    = {upSync_q[1], downSync_q[1]};
  reg  [1:0] rxLevel_q;
  reg        rxNrzi_q;
  reg  [4:0] rxShift_q;
  reg  [2:0] rxCnt_q;
  // any step between the three line levels toggles the nrzi stream
  wire       rxChange   = (rxLevel != rxLevel_q);
  wire       rxNrziNxt  = rxNrzi_q ^ rxChange;
  wire       rxNrzBit   = rxNrziNxt ^ rxNrzi_q;
  wire [4:0] rxShiftNxt = {rxShift_q[3:0], rxNrzBit};

  // no alignment: symbols are cut on a free-running five-bit count
  always @(posedge clock) begin
    if (!rst_n) begin
      rxLevel_q     <= 2'h0;
      rxNrzi_q      <= 1'b0;
      rxShift_q     <= 5'h00;
      rxCnt_q       <= 3'h0;
      rxSymbol      <= 5'h00;
      rxSymbolValid <= 1'b0;
      rxSerialNrz   <= 1'b0;
      rxSerialValid <= 1'b0;
    end else begin
      rxSymbolValid <= 1'b0;
      rxSerialValid <= 1'b0;
      if (bitEn) begin
        rxLevel_q     <= rxLevel;
        rxNrzi_q      <= rxNrziNxt;
        rxSerialNrz   <= rxNrzBit;
        rxSerialValid <= 1'b1;
        rxShift_q     <= rxShiftNxt;
        if (rxCnt_q == `BITS_PER_CG - 3'h1) begin
          rxCnt_q       <= 3'h0;
          rxSymbol      <= rxShiftNxt;
          rxSymbolValid <= 1'b1;
        end else begin
          rxCnt_q <= rxCnt_q + 3'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // signal detect
  // ------------------------------------------------------------
  // isolated link pulses are followed by long quiet and never fill the count
  reg  [7:0] actCnt_q;
  reg  [7:0] quietCnt_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      actCnt_q     <= 8'h00;
      quietCnt_q   <= 8'h00;
      signalDetect <= 1'b0;
    end else if (bitEn) begin
      if (rxLevel != 2'h0) begin
        quietCnt_q <= 8'h00;
        if (actCnt_q != 8'hFF) begin
          actCnt_q <= actCnt_q + 8'h01;
        end
      end else if (quietCnt_q == `SD_COUNT) begin
        actCnt_q <= 8'h00;
      end else begin
        quietCnt_q <= quietCnt_q + 8'h01;
      end
      signalDetect <= (actCnt_q >= SD_THRESHOLD[7:0]) && (quietCnt_q != `SD_COUNT);
    end
  end

endmodule
`default_nettype wire

// [core/line_coding_defines.vh]
// constants for the 100 Mb/s line coding path
`ifndef LINE_CODING_DEFINES_VH
`define LINE_CODING_DEFINES_VH
`define CG_IDLE     5'h1F
`define CG_HALT     5'h04
`define CG_SSD1     5'h18
`define CG_SSD2     5'h11
`define CG_ESD1     5'h0D
`define CG_ESD2     5'h07
`define BITS_PER_CG 3'h5
`define LFSR_W      11
`define SEED_MIX    11'h5A5
`define LFSR_RST    11'h001
// signal detect drops, and its active count clears, after this many quiet bit times
`define SD_COUNT    8'h40
`endif

// [testbench/lc_properties.sv]
// assertions on the line coding path ports
`timescale 1ns/1ns
`default_nettype none
module lc_checker (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       bitEn,
  input wire logic       txNibbleTake,
  input wire logic       mltPlus,
  input wire logic       mltMinus,
  input wire logic [4:0] rxSymbol,
  input wire logic       rxSymbolValid,
  input wire logic       rxSerialValid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a group is five bit times, so never two takes within four cycles
  sequence noTake4;
    !txNibbleTake [*4];
  endsequence
  mlt_exclusive_a: assert property (!(mltPlus && mltMinus))
    else $error("phases overlap");
  mlt_hold_a: assert property (!$past(bitEn) |-> $stable({mltPlus, mltMinus}))
    else $error("line moved off bit");
  take_on_bit_a: assert property (txNibbleTake |-> bitEn)
    else $error("take off bit");
  take_gap_a: assert property (txNibbleTake |=> noTake4)
    else $error("takes too close");
  rx_serial_a: assert property (rxSerialValid |-> $past(bitEn))
    else $error("serial off bit");
  rx_with_bit_a: assert property (rxSymbolValid |-> rxSerialValid)
    else $error("symbol off bit");
  rx_gap_a: assert property (rxSymbolValid |=> !rxSymbolValid [*4])
    else $error("symbols too close");
  rx_stand_a: assert property (!rxSymbolValid |-> $stable(rxSymbol))
    else $error("symbol changed");
  // side that drove the last nonzero level
  logic lastPlus_q;
  always @(posedge clock) begin
    if (!rst_n) lastPlus_q <= 1'b0;
    else if (mltPlus || mltMinus) lastPlus_q <= mltPlus;
  end
  mlt_alt_plus_a: assert property ($rose(mltPlus) |-> !lastPlus_q)
    else $error("plus side repeated");
  mlt_alt_minus_a: assert property ($rose(mltMinus) |-> lastPlus_q)
    else $error("minus side repeated");
endmodule
bind fast_ethernet_line_coding_path lc_checker u_lc_checker (.*);
`default_nettype wire

// [testbench/mac_tx_model.sv]
// MAC side model: sends one frame of nibbles per start pulse
`timescale 1ns/1ns
`default_nettype none
module mac_tx_model (
  input  wire logic       clock,
  input  wire logic       start,
  input  wire logic       txNibbleTake,
  output var  logic       txEn,
  output var  logic [3:0] txData
);
  logic [4:0] idx_q;
  initial {txEn, txData, idx_q} = 10'h000;
  // preamble byte, then 0..F; data left inverted once released
  always @(posedge clock) begin
    if (start) begin
      {txEn, txData, idx_q} <= 10'h2A0;
    end else if (txNibbleTake && txEn) begin
      idx_q  <= idx_q + 5'h01;
      txEn   <= idx_q != 5'h11;
      txData <= idx_q == 5'h11 ? ~txData : idx_q == 5'h00 ? 4'h5 : idx_q[3:0] - 4'h1;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_fast_ethernet_line_coding_path.sv]
// self-checking bench for the line coding path
`timescale 1ns/1ns
`default_nettype none
module tb_fast_ethernet_line_coding_path;
  localparam logic [95:0] EXP = 96'h7934_AA96_E7CA_76BE_B7CE_B4FF;
  localparam logic [94:0] EXPH = {{16{5'h04}}, 5'h0D, 5'h07, 5'h1F};
  logic [94:0] expBits;
  logic        clock, rst_n, bitEn, txEn, txErr, txNibbleTake, mltPlus, mltMinus;
  logic        lineUp, lineDown, rxSymbolValid, rxSerialNrz, rxSerialValid, signalDetect;
  logic        run, start, quiet, pulse, sb, k, d;
  logic [1:0]  div, lvl;
  logic [3:0]  txData;
  logic [4:0]  phy_address_strap, rxSymbol, rxSr;
  logic [9:0]  win;
  logic [10:0] ks;
  int          n_fail = 0, num_checks = 0, nSync = 0, ptr = 95, frames = 0;
  fast_ethernet_line_coding_path u_fast_ethernet_line_coding_path (.*);
  mac_tx_model u_mac_tx_model (.*);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #2_000_000 n_fail++;
    end_sim();
  end
  // one bit time every four clocks; line looped back unless faking link pulses
  always @(posedge clock) begin
    div      <= div + 2'h1;
    bitEn    <= run && div == 2'h3;
    lineUp   <= quiet ? pulse : mltPlus;
    lineDown <= !quiet && mltMinus;
  end
  // keystream learnt over idles, then extended by x^11 + x^9 + 1
  always @(negedge clock) begin
    if (rxSerialValid) rxSr = {rxSr[3:0], rxSerialNrz};
    if (rxSymbolValid) check(rxSymbol, rxSr);
    if (bitEn) begin
      sb = {mltPlus, mltMinus} != lvl;
      lvl = {mltPlus, mltMinus};
      k = nSync < 20 ? !sb : ks[10] ^ ks[8];
      nSync++;
      ks = {ks[9:0], k};
      d = sb ^ k;
      if (ptr < 95) begin
        check({4'h0, d}, {4'h0, expBits[94 - ptr]});
        ptr++;
        if (ptr == 95) frames++;
      end
      win = {win[8:0], d};
      if (win == 10'h311) ptr = 0;
    end
  end
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic link_pulses();
    // more pulses than the detect threshold, so only the quiet clear keeps it low
    repeat (12) begin
      repeat (316) @(posedge clock);
      pulse <= 1'b1;
      repeat (4) @(posedge clock);
      pulse <= 1'b0;
      check({4'h0, signalDetect}, 5'h00);
    end
  endtask
  task automatic send_frame(input logic [94:0] exp, input logic err);
    int f0;
    f0 = frames;
    expBits = exp;
    txErr <= err;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    for (int i = 0; i < 900 && frames == f0; i++) @(posedge clock);
    check({4'h0, frames != f0}, 5'h01);
    txErr <= 1'b0;
  endtask
  initial begin
    {rst_n, run, start, pulse, bitEn, div, lvl, txErr} = 10'h000;
    {quiet, lineUp, lineDown, phy_address_strap} = 8'h93;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    run <= 1'b1;
    link_pulses();
    quiet <= 1'b0;
    send_frame(EXP[94:0], 1'b0);
    send_frame(EXP[94:0], 1'b0);
    send_frame(EXPH, 1'b1);
    check({4'h0, signalDetect}, 5'h01);
    end_sim();
  end
endmodule
`default_nettype wire
